// [hw/amd_pkg.sv]
// addressing mode decoder: shared constants, mode enumeration and mode helpers
// ==========================================================================
// Summary of operation
// - seventeen addressing modes in seven classes
// - long submodes reach whole 64 Kbyte space
// - short non-indexed submodes reach page zero only
// - read-modify-write opcodes decode short forms only
// - inherent instruction is one byte, two with a prefix
// - immediate instruction is opcode plus operand
// - short direct address is one byte
// - long direct address is two bytes
// - indexed address is unsigned index plus offset
// - no-offset indexed uses index as address
// - short indexed sum carries into ninth bit
// - long indexed adds two-byte offset
// - indirect modes read address from memory pointer
// - short indirect fetches byte pointer, page zero
// - relative target is next PC plus signed byte
// - stop instruction forces reset, no stop state
// - wait instruction idles until interrupt arrives
// - long indirect fetches word pointer from page zero
// - prefix 90 selects second index register
// - prefix 92 converts to indirect forms
// - prefix 91 selects second index for indirect indexed
`default_nettype none
package amd_pkg;
  // ==========================================================================
  // addressing modes, seven classes
  typedef enum logic [4:0] {
    AMD_INH, AMD_IMM,
    AMD_DIR_S, AMD_DIR_L,
    AMD_IDX_0, AMD_IDX_S, AMD_IDX_L,
    AMD_IND_S, AMD_IND_L, AMD_IIX_S, AMD_IIX_L,
    AMD_REL_D, AMD_REL_I,
    AMD_BIT_D, AMD_BIT_I, AMD_BIT_DR, AMD_BIT_IR
  } amd_mode_t;

  // ==========================================================================
  // prefix bytes and special opcodes
  localparam logic [7:0] AMD_SECOND_INDEX_PREFIX = 8'h90;
  localparam logic [7:0] AMD_SECOND_INDEX_INDIRECT_PREFIX = 8'h91;
  localparam logic [7:0] AMD_INDIRECT_PREFIX = 8'h92;
  localparam logic [7:0] AMD_NO_PREFIX = 8'h00;
  localparam logic [7:0] AMD_STOP_INSTRUCTION = 8'h8E;
  localparam logic [7:0] AMD_WAIT_INTERRUPT_INSTRUCTION = 8'h8F;
  localparam logic [7:0] AMD_CALL_RELATIVE = 8'hAD;
  localparam logic [7:0] AMD_PAGE_ZERO = 8'h00;
  localparam logic [15:0] AMD_PC_RESET = 16'h0000;
  localparam logic [15:0] AMD_IDX_SHORT_MAX = 16'h01FE;

  // operand bytes that follow the opcode for each mode
  function automatic logic [1:0] amd_opnd_bytes(input amd_mode_t m);
    case (m)
      AMD_INH, AMD_IDX_0: amd_opnd_bytes = 2'h0;
      AMD_DIR_L, AMD_IDX_L, AMD_BIT_DR, AMD_BIT_IR: amd_opnd_bytes = 2'h2;
      default: amd_opnd_bytes = 2'h1;
    endcase
  endfunction

  // bytes of pointer read from page zero for each mode
  function automatic logic [1:0] amd_ptr_bytes(input amd_mode_t m);
    case (m)
      AMD_IND_L, AMD_IIX_L: amd_ptr_bytes = 2'h2;
      AMD_IND_S, AMD_IIX_S, AMD_REL_I, AMD_BIT_I, AMD_BIT_IR: amd_ptr_bytes = 2'h1;
      default: amd_ptr_bytes = 2'h0;
    endcase
  endfunction
endpackage
`default_nettype wire

// [hw/amd_dec_if.sv]
// addressing mode decoder: internal carrier between sequencer, mode table and address unit
`timescale 1ns/1ps
`default_nettype none
interface amd_dec_if;
  import amd_pkg::*;
  logic [7:0] opcode;
  logic [7:0] prefix;
  amd_mode_t mode;
  logic [1:0] n_opnd;
  logic [1:0] n_ptr;
  logic use_y;
  logic bad_prefix;
  logic [7:0] opnd0;
  logic [7:0] opnd1;
  logic [15:0] ptr_val;
  logic [7:0] idx;
  logic [15:0] next_pc;
  logic [15:0] ea;
  logic [15:0] target;
  modport table_mp (input opcode, prefix, output mode, n_opnd, n_ptr, use_y, bad_prefix);
  modport ea_mp (input mode, opnd0, opnd1, ptr_val, idx, next_pc, output ea, target);
  modport core_mp (output opcode, prefix, opnd0, opnd1, ptr_val, idx, next_pc,
                   input mode, n_opnd, n_ptr, use_y, bad_prefix, ea, target);
endinterface
`default_nettype wire

// [hw/amd_mode_table.sv]
// addressing mode decoder: opcode and prefix to mode classification
`timescale 1ns/1ps
`default_nettype none
module amd_mode_table import amd_pkg::*; (
  amd_dec_if.table_mp dec
);
  logic ind;

  // ==========================================================================
  // high nibble selects the mode row; prefixes bend it
  always_comb begin
    ind = (dec.prefix == AMD_INDIRECT_PREFIX) ||
          (dec.prefix == AMD_SECOND_INDEX_INDIRECT_PREFIX);
    dec.use_y = (dec.prefix == AMD_SECOND_INDEX_PREFIX) ||
                (dec.prefix == AMD_SECOND_INDEX_INDIRECT_PREFIX);
    case (dec.opcode[7:4])
      4'h0: dec.mode = ind ? AMD_BIT_IR : AMD_BIT_DR;
      4'h1: dec.mode = ind ? AMD_BIT_I : AMD_BIT_D;
      4'h2: dec.mode = ind ? AMD_REL_I : AMD_REL_D;
      // read-modify-write rows have no long form at all
      4'h3: dec.mode = ind ? AMD_IND_S : AMD_DIR_S;
      4'h6: dec.mode = ind ? AMD_IIX_S : AMD_IDX_S;
      4'h7: dec.mode = AMD_IDX_0;
      4'hA: dec.mode = (dec.opcode == AMD_CALL_RELATIVE) ?
                       (ind ? AMD_REL_I : AMD_REL_D) : AMD_IMM;
      4'hB: dec.mode = ind ? AMD_IND_S : AMD_DIR_S;
      4'hC: dec.mode = ind ? AMD_IND_L : AMD_DIR_L;
      4'hD: dec.mode = ind ? AMD_IIX_L : AMD_IDX_L;
      4'hE: dec.mode = ind ? AMD_IIX_S : AMD_IDX_S;
      4'hF: dec.mode = AMD_IDX_0;
      default: dec.mode = AMD_INH;
    endcase
    dec.n_opnd = amd_opnd_bytes(dec.mode);
    dec.n_ptr = amd_ptr_bytes(dec.mode);
    // the second-index indirect prefix only makes sense on indirect indexed forms
    dec.bad_prefix = (dec.prefix == AMD_SECOND_INDEX_INDIRECT_PREFIX) &&
                     (dec.mode != AMD_IIX_S) && (dec.mode != AMD_IIX_L);
  end
endmodule
`default_nettype wire

// [hw/amd_ea_unit.sv]
// addressing mode decoder: effective address and relative target arithmetic
`timescale 1ns/1ps
`default_nettype none
module amd_ea_unit import amd_pkg::*; (
  amd_dec_if.ea_mp dec
);
  logic [7:0] disp;

  // ==========================================================================
  // effective address per mode; index sums are unsigned
  always_comb begin
    case (dec.mode)
      AMD_DIR_L: dec.ea = {dec.opnd0, dec.opnd1};
      AMD_IDX_0: dec.ea = {AMD_PAGE_ZERO, dec.idx};
      AMD_IDX_S: dec.ea = {8'h00, dec.opnd0} + {8'h00, dec.idx};
      AMD_IDX_L: dec.ea = {dec.opnd0, dec.opnd1} + {8'h00, dec.idx};
      AMD_IND_S, AMD_BIT_I, AMD_BIT_IR:
        dec.ea = {AMD_PAGE_ZERO, dec.ptr_val[7:0]};
      AMD_IND_L: dec.ea = dec.ptr_val;
      AMD_IIX_S: dec.ea = {8'h00, dec.ptr_val[7:0]} + {8'h00, dec.idx};
      AMD_IIX_L: dec.ea = dec.ptr_val + {8'h00, dec.idx};
      AMD_INH, AMD_IMM, AMD_REL_D, AMD_REL_I: dec.ea = 16'h0000;
      default: dec.ea = {AMD_PAGE_ZERO, dec.opnd0};
    endcase
  end

  // ==========================================================================
  // displacement source; next_pc is already past every operand byte
  always_comb begin
    case (dec.mode)
      AMD_REL_I: disp = dec.ptr_val[7:0];
      AMD_BIT_DR, AMD_BIT_IR: disp = dec.opnd1;
      default: disp = dec.opnd0;
    endcase
    dec.target = dec.next_pc + {{8{disp[7]}}, disp};
  end
endmodule
`default_nettype wire

// [hw/amd_decoder.sv]
// addressing mode decoder: fetch sequencer, operand collection and result registers
`timescale 1ns/1ps
`default_nettype none
module amd_decoder import amd_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_start,
  input wire logic [15:0] i_pc,
  input wire logic [7:0] i_x,
  input wire logic [7:0] i_y,
  input wire logic i_irq,
  input wire logic i_mem_ack,
  input wire logic [7:0] i_mem_data,
  output logic o_mem_rd,
  output logic [15:0] o_mem_addr,
  output logic o_busy,
  output logic o_done,
  output logic [4:0] o_mode,
  output logic [2:0] o_len,
  output logic [7:0] o_opcode,
  output logic o_use_y,
  output logic o_illegal,
  output logic [2:0] o_bit_num,
  output logic [15:0] o_ea,
  output logic [15:0] o_target,
  output logic [15:0] o_next_pc,
  output logic o_stop_reset,
  output logic o_wait_state
);
  typedef enum logic [2:0] {ST_IDLE, ST_OP, ST_OPND, ST_PTR, ST_DONE, ST_WAIT} amd_state_t;

  amd_state_t state;
  logic [15:0] pc;
  logic [15:0] start_pc;
  logic [7:0] opcode;
  logic [7:0] prefix;
  logic [7:0] opnd0;
  logic [7:0] opnd1;
  logic [15:0] ptr_val;
  logic [1:0] cnt;
  logic opnd_last;
  logic ptr_last;
  logic is_prefix;

  amd_dec_if dec ();

  // ==========================================================================
  // mode table and address unit
  amd_mode_table u_table (
    .dec(dec.table_mp)
  );

  amd_ea_unit u_ea (
    .dec(dec.ea_mp)
  );

  assign dec.opcode = opcode;
  assign dec.prefix = prefix;
  assign dec.opnd0 = opnd0;
  assign dec.opnd1 = opnd1;
  assign dec.ptr_val = ptr_val;
  assign dec.idx = dec.use_y ? i_y : i_x;
  assign dec.next_pc = pc; // pc has walked past all operand bytes here

  // ==========================================================================
  // fetch handshake: a read is held until the memory acknowledges it
  assign is_prefix = (prefix == AMD_NO_PREFIX) &&
                     ((i_mem_data == AMD_SECOND_INDEX_PREFIX) ||
                      (i_mem_data == AMD_SECOND_INDEX_INDIRECT_PREFIX) ||
                      (i_mem_data == AMD_INDIRECT_PREFIX));
  assign opnd_last = (cnt == dec.n_opnd);
  assign ptr_last = (cnt == dec.n_ptr);

  // read request and address
  always_comb begin
    o_mem_rd = 1'b0;
    o_mem_addr = pc;
    case (state)
      ST_OP: o_mem_rd = 1'b1;
      ST_OPND: o_mem_rd = !opnd_last; // exactly n_opnd reads
      ST_PTR: begin
        o_mem_rd = !ptr_last;
        // pointer lives in page zero; a word pointer wraps inside it
        o_mem_addr = {AMD_PAGE_ZERO, opnd0 + {6'h00, cnt}};
      end
      default: o_mem_rd = 1'b0;
    endcase
  end

  assign o_busy = (state != ST_IDLE);

  // ==========================================================================
  // sequencer state
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: if (i_start) state <= ST_OP;
        ST_OP: if (i_mem_ack && !is_prefix) state <= ST_OPND;
        ST_OPND: begin
          if (opnd_last) begin
            state <= (dec.n_ptr != 2'h0) ? ST_PTR : ST_DONE;
          end
        end
        ST_PTR: if (ptr_last) state <= ST_DONE;
        ST_DONE: begin
          // wait holds the core until an interrupt; stop never enters a state
          if (dec.mode == AMD_INH && opcode == AMD_WAIT_INTERRUPT_INSTRUCTION) begin
            state <= ST_WAIT;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_WAIT: if (i_irq) state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // program counter: one step per fetched instruction byte
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pc <= AMD_PC_RESET;
      start_pc <= AMD_PC_RESET;
    end else if (state == ST_IDLE && i_start) begin
      pc <= i_pc;
      start_pc <= i_pc;
    end else if (i_mem_ack && (state == ST_OP || (state == ST_OPND && !opnd_last))) begin
      pc <= pc + 16'h0001;
    end
  end

  // ==========================================================================
  // prefix and opcode capture; only one prefix is taken per instruction
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      prefix <= AMD_NO_PREFIX;
      opcode <= 8'h00;
    end else if (state == ST_IDLE && i_start) begin
      prefix <= AMD_NO_PREFIX;
    end else if (state == ST_OP && i_mem_ack) begin
      if (is_prefix) begin
        prefix <= i_mem_data;
      end else begin
        opcode <= i_mem_data;
      end
    end
  end

  // ==========================================================================
  // operand and pointer bytes; a counter shared by both phases
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cnt <= 2'h0;
    end else if (state == ST_OP || (state == ST_OPND && opnd_last)) begin
      cnt <= 2'h0;
    end else if (i_mem_ack && ((state == ST_OPND && !opnd_last) ||
                               (state == ST_PTR && !ptr_last))) begin
      cnt <= cnt + 2'h1;
    end
  end

  // operand bytes in fetch order: first byte is the high one of a word
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      opnd0 <= 8'h00;
      opnd1 <= 8'h00;
    end else if (state == ST_OP) begin
      opnd0 <= 8'h00;
      opnd1 <= 8'h00;
    end else if (state == ST_OPND && i_mem_ack && !opnd_last) begin
      if (cnt == 2'h0) begin
        opnd0 <= i_mem_data;
      end else begin
        opnd1 <= i_mem_data;
      end
    end
  end

  // pointer shifts in high byte first; a byte pointer ends in the low byte
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ptr_val <= 16'h0000;
    end else if (state == ST_OP) begin
      ptr_val <= 16'h0000;
    end else if (state == ST_PTR && i_mem_ack && !ptr_last) begin
      ptr_val <= {ptr_val[7:0], i_mem_data};
    end
  end

  // ==========================================================================
  // result registers, loaded once per instruction
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_mode <= 5'h00;
      o_len <= 3'h0;
      o_opcode <= 8'h00;
      o_use_y <= 1'b0;
      o_illegal <= 1'b0;
      o_bit_num <= 3'h0;
      o_ea <= 16'h0000;
      o_target <= 16'h0000;
      o_next_pc <= AMD_PC_RESET;
    end else if (state == ST_DONE) begin
      o_mode <= dec.mode;
      // length counts prefix, opcode and operand bytes
      o_len <= {2'h0, prefix != AMD_NO_PREFIX} + 3'h1 + {1'b0, dec.n_opnd};
      o_opcode <= opcode;
      o_use_y <= dec.use_y;
      o_illegal <= dec.bad_prefix;
      o_bit_num <= opcode[3:1];
      o_ea <= dec.ea;
      o_target <= dec.target;
      o_next_pc <= pc;
    end
  end

  // ==========================================================================
  // completion, stop and wait indications
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_done <= 1'b0;
      o_stop_reset <= 1'b0;
      o_wait_state <= 1'b0;
    end else begin
      o_done <= (state == ST_DONE);
      // stop is refused as a state and turned into a reset request
      o_stop_reset <= (state == ST_DONE) && (dec.mode == AMD_INH) &&
                      (opcode == AMD_STOP_INSTRUCTION);
      o_wait_state <= (state == ST_DONE && dec.mode == AMD_INH &&
                       opcode == AMD_WAIT_INTERRUPT_INSTRUCTION) ||
                      (state == ST_WAIT && !i_irq);
    end
  end

  // ==========================================================================
  // checks on the decoded results
  logic [15:0] rel_diff;
  logic [15:0] len_pc;
  assign rel_diff = o_target - o_next_pc;
  assign len_pc = start_pc + {13'h0000, o_len};

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  property p_inherent_len;
    o_done && o_mode == 5'(AMD_INH) && !o_use_y |-> o_len == 3'h1;
  endproperty
  a_inherent_len: assert property (p_inherent_len) else $error("inherent length wrong");

  property p_imm_len;
    o_done && o_mode == 5'(AMD_IMM) |-> o_len == (o_use_y ? 3'h3 : 3'h2);
  endproperty
  a_imm_len: assert property (p_imm_len) else $error("immediate length wrong");

  property p_short_page0;
    o_done && (o_mode == 5'(AMD_DIR_S) || o_mode == 5'(AMD_IND_S) ||
               o_mode == 5'(AMD_IDX_0)) |-> o_ea[15:8] == 8'h00;
  endproperty
  a_short_page0: assert property (p_short_page0) else $error("short mode left page zero");

  property p_idx_short_range;
    o_done && o_mode == 5'(AMD_IDX_S) |-> o_ea <= AMD_IDX_SHORT_MAX;
  endproperty
  a_idx_short_range: assert property (p_idx_short_range) else $error("short index range");

  property p_long_dir_len;
    o_done && o_mode == 5'(AMD_DIR_L) |-> o_len == (o_use_y ? 3'h4 : 3'h3);
  endproperty
  a_long_dir_len: assert property (p_long_dir_len) else $error("long direct length");

  property p_rel_range;
    o_done && o_mode == 5'(AMD_REL_D) |-> rel_diff < 16'h0080 || rel_diff >= 16'hFF80;
  endproperty
  a_rel_range: assert property (p_rel_range) else $error("relative target range");

  property p_next_pc;
    o_done |-> o_next_pc == len_pc;
  endproperty
  a_next_pc: assert property (p_next_pc) else $error("pc not past operands");

  property p_stop_reset;
    o_done && o_mode == 5'(AMD_INH) && o_opcode == AMD_STOP_INSTRUCTION
      |-> o_stop_reset ##1 !o_wait_state;
  endproperty
  a_stop_reset: assert property (p_stop_reset) else $error("stop did not reset");

  sequence s_wait_decoded;
    o_done && o_mode == 5'(AMD_INH) && o_opcode == AMD_WAIT_INTERRUPT_INSTRUCTION;
  endsequence
  sequence s_irq_free;
    !i_irq [*2];
  endsequence
  property p_wait_hold;
    s_wait_decoded ##0 (o_wait_state && !i_irq) |=> o_wait_state;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("wait state dropped");

  property p_wait_release;
    o_wait_state && i_irq |=> !o_wait_state && !o_busy;
  endproperty
  a_wait_release: assert property (p_wait_release) else $error("wait not released");

  property p_wait_stays;
    s_wait_decoded ##0 s_irq_free |-> o_wait_state;
  endproperty
  a_wait_stays: assert property (p_wait_stays) else $error("wait left early");

  // ==========================================================================
  // fetch handshake, pointer page and stop/wait side checks
  // a request must not move before its answer, or the byte lands in the wrong field
  property p_rd_hold;
    o_mem_rd && !i_mem_ack |=> o_mem_rd && $stable(o_mem_addr);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read request not held");

  // pointer reads stay in page zero, even when a word pointer wraps
  property p_ptr_page0;
    o_mem_rd && state == ST_PTR |-> o_mem_addr[15:8] == AMD_PAGE_ZERO;
  endproperty
  a_ptr_page0: assert property (p_ptr_page0) else $error("pointer read off page zero");

  property p_long_ind_len;
    o_done && o_mode == 5'(AMD_IND_L) |-> o_len == 3'h3;
  endproperty
  a_long_ind_len: assert property (p_long_ind_len) else $error("long indirect length");

  property p_stop_idle;
    o_stop_reset |-> !o_busy && !o_wait_state;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop entered a state");

  property p_wait_busy;
    o_wait_state |-> o_busy;
  endproperty
  a_wait_busy: assert property (p_wait_busy) else $error("wait without busy");

  property p_done_pulse;
    o_done |=> !o_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
endmodule
`default_nettype wire

// [verif/addressing_mode_decoder_tb_top.sv]
// self-checking testbench for the addressing mode decoder
`timescale 1ns/1ps
`default_nettype none
module addressing_mode_decoder_tb_top;
  import amd_pkg::*;
  logic i_clk, i_rst_b, i_start, i_irq, i_mem_ack;
  logic [15:0] i_pc;
  logic [7:0] i_x, i_y, i_mem_data;
  logic o_mem_rd, o_busy, o_done, o_use_y, o_illegal, o_stop_reset, o_wait_state;
  logic [15:0] o_mem_addr, o_ea, o_target, o_next_pc;
  logic [4:0] o_mode;
  logic [2:0] o_len, o_bit_num;
  logic [7:0] o_opcode;
  logic [7:0] mem [0:65535];
  int n_fail = 0;
  int checks = 0;
  int lat = 0;
  int wait_cnt = 0;
  int cycles = 0;

  // ==========================================================================
  // clock, stimulus start values and hang guard
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    i_rst_b = 1'b0;
    i_start = 1'b0;
    i_irq = 1'b0;
    i_mem_ack = 1'b0;
    i_pc = 16'h0000;
    i_x = 8'h00;
    i_y = 8'h00;
    i_mem_data = 8'h00;
  end
  // ceiling well above the few hundred cycles the scenarios need
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      close_out();
    end
  end

  amd_decoder i_dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(i_start), .i_pc(i_pc), .i_x(i_x),
    .i_y(i_y), .i_irq(i_irq), .i_mem_ack(i_mem_ack), .i_mem_data(i_mem_data),
    .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr), .o_busy(o_busy), .o_done(o_done),
    .o_mode(o_mode), .o_len(o_len), .o_opcode(o_opcode), .o_use_y(o_use_y),
    .o_illegal(o_illegal), .o_bit_num(o_bit_num), .o_ea(o_ea), .o_target(o_target),
    .o_next_pc(o_next_pc), .o_stop_reset(o_stop_reset), .o_wait_state(o_wait_state)
  );

  // ==========================================================================
  // memory answer: ack after lat idle cycles, data garbled whenever not acked
  always @(posedge i_clk) begin
    if (o_mem_rd === 1'b1 && !i_mem_ack && wait_cnt >= lat) begin
      i_mem_ack <= 1'b1;
      i_mem_data <= mem[o_mem_addr];
      wait_cnt <= 0;
    end else begin
      i_mem_ack <= 1'b0;
      i_mem_data <= ~i_mem_data;
      wait_cnt <= (o_mem_rd === 1'b1 && !i_mem_ack) ? wait_cnt + 1 : 0;
    end
  end

  // ==========================================================================
  // shared helpers
  task automatic close_out();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // four instruction bytes, first byte at the lowest address
  task automatic put(input logic [15:0] a, input logic [31:0] w);
    mem[a] = w[31:24];
    mem[a + 16'h1] = w[23:16];
    mem[a + 16'h2] = w[15:8];
    mem[a + 16'h3] = w[7:0];
  endtask
  // one decode; returns in the cycle of o_done with results settled
  task automatic dec(input logic [15:0] pc, input logic [7:0] x, input logic [7:0] y,
                     input amd_mode_t m, input logic [2:0] len, input logic [15:0] ea);
    int n;
    @(posedge i_clk);
    i_pc <= pc;
    i_x <= x;
    i_y <= y;
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    #1;
    n = 0;
    while (o_done !== 1'b1 && n < 60) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk("done", 16'h0001, 16'(o_done));
    chk("mode", 16'(m), 16'(o_mode));
    chk("len", 16'(len), 16'(o_len));
    chk("ea", ea, o_ea);
    chk("next_pc", pc + 16'(len), o_next_pc);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_plain();
    put(16'h0100, 32'h4F000000);
    dec(16'h0100, 8'h00, 8'h00, AMD_INH, 3'h1, 16'h0000);
    chk("use_y", 16'h0000, 16'(o_use_y));
    put(16'h0110, 32'hA6550000);
    dec(16'h0110, 8'h00, 8'h00, AMD_IMM, 3'h2, 16'h0000);
    put(16'h0120, 32'hB6100000);
    dec(16'h0120, 8'h00, 8'h00, AMD_DIR_S, 3'h2, 16'h0010);
    put(16'h0130, 32'hC6100000);
    dec(16'h0130, 8'h00, 8'h00, AMD_DIR_L, 3'h3, 16'h1000);
    put(16'h0140, 32'h3C200000);
    dec(16'h0140, 8'h00, 8'h00, AMD_DIR_S, 3'h2, 16'h0020);
  endtask
  task automatic t_indexed();
    put(16'h0150, 32'hF6000000);
    dec(16'h0150, 8'hFF, 8'h00, AMD_IDX_0, 3'h1, 16'h00FF);
    put(16'h0160, 32'h90F60000);
    dec(16'h0160, 8'h11, 8'h80, AMD_IDX_0, 3'h2, 16'h0080);
    chk("use_y", 16'h0001, 16'(o_use_y));
    put(16'h0170, 32'hE6FF0000);
    dec(16'h0170, 8'hFF, 8'h00, AMD_IDX_S, 3'h2, 16'h01FE);
    put(16'h0180, 32'hD6123400);
    dec(16'h0180, 8'h56, 8'h00, AMD_IDX_L, 3'h3, 16'h128A);
  endtask
  // slow memory here, so every read waits three cycles for its answer
  task automatic t_indirect();
    lat = 3;
    mem[16'h0010] = 8'h80;
    mem[16'h0011] = 8'h34;
    put(16'h0200, 32'h92B61000);
    dec(16'h0200, 8'h00, 8'h00, AMD_IND_S, 3'h3, 16'h0080);
    put(16'h0210, 32'h92C61000);
    dec(16'h0210, 8'h00, 8'h00, AMD_IND_L, 3'h3, 16'h8034);
    put(16'h0220, 32'h91E61000);
    dec(16'h0220, 8'h00, 8'h90, AMD_IIX_S, 3'h3, 16'h0110);
    chk("use_y", 16'h0001, 16'(o_use_y));
    chk("illegal", 16'h0000, 16'(o_illegal));
    put(16'h0230, 32'h91B61000);
    dec(16'h0230, 8'h00, 8'h00, AMD_IND_S, 3'h3, 16'h0080);
    chk("illegal", 16'h0001, 16'(o_illegal));
    put(16'h0240, 32'h92D61000);
    dec(16'h0240, 8'h01, 8'h00, AMD_IIX_L, 3'h3, 16'h8035);
    lat = 0;
  endtask
  task automatic t_relative();
    put(16'h1000, 32'h20800000);
    dec(16'h1000, 8'h00, 8'h00, AMD_REL_D, 3'h2, 16'h0000);
    chk("target", 16'h0F82, o_target);
    put(16'h1010, 32'h207F0000);
    dec(16'h1010, 8'h00, 8'h00, AMD_REL_D, 3'h2, 16'h0000);
    chk("target", 16'h1091, o_target);
    put(16'h1020, 32'h92201000);
    dec(16'h1020, 8'h00, 8'h00, AMD_REL_I, 3'h3, 16'h0000);
    chk("target", 16'h0FA3, o_target);
    put(16'h1030, 32'hAD050000);
    dec(16'h1030, 8'h00, 8'h00, AMD_REL_D, 3'h2, 16'h0000);
    chk("target", 16'h1037, o_target);
  endtask
  task automatic t_bit();
    put(16'h0300, 32'h1E100000);
    dec(16'h0300, 8'h00, 8'h00, AMD_BIT_D, 3'h2, 16'h0010);
    chk("bit_num", 16'h0007, 16'(o_bit_num));
    put(16'h0310, 32'h0E100500);
    dec(16'h0310, 8'h00, 8'h00, AMD_BIT_DR, 3'h3, 16'h0010);
    chk("target", 16'h0318, o_target);
    put(16'h0320, 32'h920310FB);
    dec(16'h0320, 8'h00, 8'h00, AMD_BIT_IR, 3'h4, 16'h0080);
    chk("target", 16'h031F, o_target);
    chk("bit_num", 16'h0001, 16'(o_bit_num));
    put(16'h0330, 32'h921E1000);
    dec(16'h0330, 8'h00, 8'h00, AMD_BIT_I, 3'h3, 16'h0080);
  endtask
  task automatic t_stop_wait();
    put(16'h0400, 32'h8E000000);
    dec(16'h0400, 8'h00, 8'h00, AMD_INH, 3'h1, 16'h0000);
    chk("stop_reset", 16'h0001, 16'(o_stop_reset));
    chk("opcode", 16'h008E, 16'(o_opcode));
    @(posedge i_clk);
    #1;
    chk("stop_reset", 16'h0000, 16'(o_stop_reset));
    put(16'h0410, 32'h8F000000);
    dec(16'h0410, 8'h00, 8'h00, AMD_INH, 3'h1, 16'h0000);
    chk("wait_state", 16'h0001, 16'(o_wait_state));
    repeat (3) @(posedge i_clk);
    #1;
    chk("busy", 16'h0001, 16'(o_busy));
    chk("wait_state", 16'h0001, 16'(o_wait_state));
    @(posedge i_clk);
    i_irq <= 1'b1;
    @(posedge i_clk);
    i_irq <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    chk("wait_state", 16'h0000, 16'(o_wait_state));
    chk("busy", 16'h0000, 16'(o_busy));
  endtask

  // ==========================================================================
  // main sequence: reset held five cycles, then every scenario in turn
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_plain();
    t_indexed();
    t_indirect();
    t_relative();
    t_bit();
    t_stop_wait();
    repeat (2) @(posedge i_clk);
    close_out();
  end
endmodule
`default_nettype wire
